/* File: src/cet_pkg.sv */
// Shared constants and types for corrected error threshold signalling
`default_nettype none

package cet_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int NUM_BANKS = 4;
  localparam int NUM_LP    = 2;
  localparam int AW        = 12;
  localparam int THR_W     = 15;
  localparam int LINES     = 16;
  localparam int LINE_W    = 4;

  // ------------------------------------------------------------
  // Model register map of the bank complex
  // ------------------------------------------------------------
  localparam logic [AW-1:0] ADDR_CAP       = 12'h000;
  localparam logic [AW-1:0] ADDR_LEG_TYPE  = 12'h001;
  localparam logic [AW-1:0] ADDR_LEG_ADDR  = 12'h002;
  localparam logic [AW-1:0] ADDR_BANK_BASE = 12'h100;
  localparam logic [1:0]    OFS_CTL        = 2'h0;
  localparam logic [1:0]    OFS_STATUS     = 2'h1;
  localparam logic [1:0]    OFS_ADDR       = 2'h2;
  localparam logic [1:0]    OFS_CTL2       = 2'h3;
  localparam int            LEG_BANK       = 0;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int CAP_CORRECTED_ERROR_INTERRUPT_BIT = 10;
  localparam int CAP_TES_BIT  = 11;
  localparam int EN_BIT       = 30;
  localparam int VALID_BIT    = 63;
  localparam int CNT_LSB      = 38;
  localparam int CNT_MSB      = 52;
  localparam logic [THR_W-1:0] THR_RESET = 15'h0000;
  localparam logic [THR_W-1:0] THR_EVERY = 15'h0001;
  localparam logic [63:0]      REG_RESET = 64'h0000_0000_0000_0000;

  // ------------------------------------------------------------
  // Implementation options
  // ------------------------------------------------------------
  localparam logic CAP_CORRECTED_ERROR_INTERRUPT_P = 1'b1;
  localparam logic CAP_TES_P  = 1'b1;
  localparam logic [NUM_BANKS-1:0] BANK_THR_SUP = 4'h7;
  localparam logic [NUM_BANKS-1:0] BANK_SYSTEM  = 4'h8;
  localparam logic [NUM_BANKS-1:0][NUM_LP-1:0] BANK_SHARE = {2'h3, 2'h3, 2'h3, 2'h1};
  localparam logic [LINE_W:0] HEALTH_THR = 5'h03;

  // ------------------------------------------------------------
  // Controller register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [AW-1:0] HOFS_ADDR = 12'h000;
  localparam logic [AW-1:0] HOFS_WLO  = 12'h004;
  localparam logic [AW-1:0] HOFS_WHI  = 12'h008;
  localparam logic [AW-1:0] HOFS_CMD  = 12'h00C;
  localparam logic [AW-1:0] HOFS_STAT = 12'h010;
  localparam logic [AW-1:0] HOFS_RLO  = 12'h014;
  localparam logic [AW-1:0] HOFS_RHI  = 12'h018;
  localparam logic [AW-1:0] HOFS_PEND = 12'h020;
  localparam logic [AW-1:0] HOFS_VEC  = 12'h2F0;
  localparam int CMD_GO_BIT    = 0;
  localparam int CMD_WR_BIT    = 1;
  localparam int STAT_DONE_BIT = 1;
  localparam int VEC_MASK_BIT  = 16;
  localparam logic [31:0] VEC_RESET = 32'h0001_0000;

  typedef enum logic [0:0] {
    CET_IDLE = 1'b0,
    CET_REQ  = 1'b1
  } cet_hst_t;

endpackage

`default_nettype wire

/* File: src/cet_if.sv */
// Link between the bank complex and the interrupt controller side
`timescale 1ns/1ns
`default_nettype none

interface cet_if;
  import cet_pkg::*;

  logic              req;
  logic              we;
  logic [AW-1:0]     addr;
  logic [63:0]       wdata;
  logic [63:0]       rdata;
  logic              ack;
  logic [NUM_LP-1:0] irq;

  modport dev (input req, we, addr, wdata, output rdata, ack, irq);
  modport hst (output req, we, addr, wdata, input rdata, ack, irq);

endinterface

`default_nettype wire

/* File: src/cet_bank.sv */
// One error bank: control, status, address and threshold control
`timescale 1ns/1ns
`default_nettype none

module cet_bank
  import cet_pkg::*;
#(
  parameter logic SUP = 1'b1
)(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ctl_we_i,
  input  wire logic        sts_we_i,
  input  wire logic        adr_we_i,
  input  wire logic        ctl2_we_i,
  input  wire logic [63:0] wdata_i,
  input  wire logic        err_i,
  input  wire logic [31:0] err_addr_i,
  output logic      [63:0] ctl_o,
  output logic      [63:0] sts_o,
  output logic      [63:0] adr_o,
  output logic      [63:0] ctl2_o,
  output logic             ovf_o
);

  typedef struct packed {
    logic [63:0]      ctl;
    logic [63:0]      sts;
    logic [63:0]      adr;
    logic [THR_W-1:0] thr;
    logic             en;
    logic             ovf;
  } cet_bank_st_t;

  cet_bank_st_t     q;
  cet_bank_st_t     n;
  logic [THR_W-1:0] cnt;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n = q;
    n.ovf = 1'b0;
    if (ctl_we_i) n.ctl = wdata_i;
    if (adr_we_i) n.adr = wdata_i;
    if (sts_we_i) n.sts = wdata_i;
    if (ctl2_we_i) begin
      n.thr = SUP ? wdata_i[THR_W-1:0] : THR_RESET;
      n.en  = wdata_i[EN_BIT];
    end
    // Error applied after the software write, so a clear never loses it
    cnt = n.sts[CNT_MSB:CNT_LSB];
    if (err_i) begin
      n.sts[VALID_BIT] = 1'b1;
      if (cnt != {THR_W{1'b1}}) cnt = cnt + 15'h0001;
      n.sts[CNT_MSB:CNT_LSB] = cnt;
      n.adr = {32'h0000_0000, err_addr_i};
      // Interrupt request independent of the bank error control word
      n.ovf = SUP & q.en & ((cnt == q.thr) | (q.thr == THR_EVERY));
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign ctl_o  = q.ctl;
  assign sts_o  = q.sts;
  assign adr_o  = q.adr;
  assign ctl2_o = {33'h0_0000_0000, q.en & SUP, 15'h0000, q.thr};
  assign ovf_o  = q.ovf;

endmodule

`default_nettype wire

/* File: src/cet_dev.sv */
// Corrected error bank complex: model registers, thresholds, cache health
//
// The implementer's own choices: the req/ack link port and the address map.
`timescale 1ns/1ns
`default_nettype none

module cet_dev
  import cet_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  cet_if.dev                     bus,
  input  wire logic              err_valid_i,
  input  wire logic [1:0]        err_bank_i,
  input  wire logic [31:0]       err_addr_i,
  input  wire logic              err_cache_i,
  input  wire logic [LINE_W-1:0] err_line_i,
  output logic                   cache_yellow_o
);

  typedef struct packed {
    logic              ack;
    logic [63:0]       rdata;
    logic [NUM_LP-1:0] irq;
    logic [LINES-1:0]  seen;
    logic [LINES-1:0]  rep;
    logic [LINE_W:0]   nrep;
    logic              yellow;
  } cet_dev_st_t;

  cet_dev_st_t          q;
  cet_dev_st_t          n;

  logic                 take;
  logic                 in_bank;
  logic [1:0]           bsel;
  logic [1:0]           bofs;
  logic                 leg_type_we;
  logic                 leg_addr_we;
  logic [63:0]          cap;
  logic [63:0]          rd;
  logic [NUM_LP-1:0]    irq_c;

  logic [NUM_BANKS-1:0] ctl_we;
  logic [NUM_BANKS-1:0] sts_we;
  logic [NUM_BANKS-1:0] adr_we;
  logic [NUM_BANKS-1:0] ctl2_we;
  logic [NUM_BANKS-1:0] err;
  logic [NUM_BANKS-1:0] ovf;
  logic [NUM_BANKS-1:0] hit;
  logic [63:0]          b_ctl  [NUM_BANKS];
  logic [63:0]          b_sts  [NUM_BANKS];
  logic [63:0]          b_adr  [NUM_BANKS];
  logic [63:0]          b_ctl2 [NUM_BANKS];

  // ------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------
  // A held request is served once, on the same edge at which ack rises
  assign take        = bus.req & ~q.ack;
  assign in_bank     = (bus.addr[AW-1:4] == ADDR_BANK_BASE[AW-1:4]);
  assign bsel        = bus.addr[3:2];
  assign bofs        = bus.addr[1:0];
  assign leg_type_we = take & bus.we & (bus.addr == ADDR_LEG_TYPE);
  assign leg_addr_we = take & bus.we & (bus.addr == ADDR_LEG_ADDR);

  assign cap = {52'h0_0000_0000_0000, CAP_TES_P, CAP_CORRECTED_ERROR_INTERRUPT_P, 2'b00, 8'(NUM_BANKS)};

  // ------------------------------------------------------------
  // Banks
  // ------------------------------------------------------------
  for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
    logic sel;
    assign sel        = take & bus.we & in_bank & (bsel == 2'(i));
    assign ctl_we[i]  = sel & (bofs == OFS_CTL);
    assign sts_we[i]  = (sel & (bofs == OFS_STATUS)) | (leg_type_we & (i == LEG_BANK));
    assign adr_we[i]  = (sel & (bofs == OFS_ADDR)) | (leg_addr_we & (i == LEG_BANK));
    // Single register per bank, shared by the threads in its BANK_SHARE mask
    assign ctl2_we[i] = sel & (bofs == OFS_CTL2);
    assign err[i]     = err_valid_i & (err_bank_i == 2'(i));
    assign hit[i]     = ovf[i] & ~BANK_SYSTEM[i];

    cet_bank #(
      .SUP (BANK_THR_SUP[i])
    ) u_bank (
      .clk_i      (clk_i),
      .resetn_i   (resetn_i),
      .ctl_we_i   (ctl_we[i]),
      .sts_we_i   (sts_we[i]),
      .adr_we_i   (adr_we[i]),
      .ctl2_we_i  (ctl2_we[i]),
      .wdata_i    (bus.wdata),
      .err_i      (err[i]),
      .err_addr_i (err_addr_i),
      .ctl_o      (b_ctl[i]),
      .sts_o      (b_sts[i]),
      .adr_o      (b_adr[i]),
      .ctl2_o     (b_ctl2[i]),
      .ovf_o      (ovf[i])
    );
  end

  // ------------------------------------------------------------
  // Read multiplexer
  // ------------------------------------------------------------
  always_comb begin
    rd = REG_RESET;
    if (bus.addr == ADDR_CAP) begin
      rd = cap;
    end else if (bus.addr == ADDR_LEG_TYPE) begin
      // Same word as the bank status; encoding differs from the old part
      rd = b_sts[LEG_BANK];
    end else if (bus.addr == ADDR_LEG_ADDR) begin
      rd = b_adr[LEG_BANK];
    end else if (in_bank) begin
      unique case (bofs)
        OFS_CTL:    rd = b_ctl[bsel];
        OFS_STATUS: rd = b_sts[bsel];
        OFS_ADDR:   rd = b_adr[bsel];
        OFS_CTL2:   rd = b_ctl2[bsel];
      endcase
    end
  end

  // ------------------------------------------------------------
  // Interrupt fan-out
  // ------------------------------------------------------------
  always_comb begin
    irq_c = '0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (hit[i]) irq_c = irq_c | BANK_SHARE[i];
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n = q;
    n.ack = take;
    if (take) n.rdata = rd;
    n.irq = irq_c;
    // Health tracks lines hit twice or more; a line is counted once
    if (err_valid_i & err_cache_i) begin
      n.seen[err_line_i] = 1'b1;
      if (q.seen[err_line_i] & ~q.rep[err_line_i]) begin
        n.rep[err_line_i] = 1'b1;
        n.nrep            = q.nrep + 5'h01;
      end
    end
    n.yellow = (n.nrep > HEALTH_THR);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign bus.ack        = q.ack;
  assign bus.rdata      = q.rdata;
  assign bus.irq        = q.irq;
  assign cache_yellow_o = q.yellow;

endmodule

`default_nettype wire

/* File: src/cet_hst.sv */
// Interrupt controller side: software command port and corrected vector entry
`timescale 1ns/1ns
`default_nettype none

module cet_hst
  import cet_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  input  wire logic [AW-1:0] avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  input  wire logic [3:0]    avs_byteenable_i,
  output logic      [31:0]   avs_readdata_o,
  output logic               avs_waitrequest_o,
  output logic [NUM_LP-1:0]  lp_irq_o,
  output logic [7:0]         lp_vector_o,
  cet_if.hst                 bus
);

  typedef struct packed {
    cet_hst_t          st;
    logic              aack;
    logic [31:0]       rdat;
    logic [AW-1:0]     maddr;
    logic [63:0]       wdat;
    logic              we;
    logic [63:0]       rsp;
    logic              done;
    logic [31:0]       vec;
    logic [NUM_LP-1:0] pend;
  } cet_hst_st_t;

  cet_hst_st_t       q;
  cet_hst_st_t       n;
  logic [31:0]       rd;
  logic [31:0]       mv;
  logic              wr_hit;
  logic              idle;
  logic              set_d;
  logic              clr_d;
  logic [NUM_LP-1:0] clr_p;

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] w, input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      be_merge[8*b +: 8] = be[b] ? w[8*b +: 8] : o[8*b +: 8];
    end
  endfunction

  // ------------------------------------------------------------
  // Register access and command sequencing
  // ------------------------------------------------------------
  always_comb begin
    n      = q;
    n.aack = (avs_read_i | avs_write_i) & ~q.aack;
    wr_hit = avs_write_i & q.aack;
    idle   = (q.st == CET_IDLE);
    set_d  = 1'b0;
    clr_d  = 1'b0;
    clr_p  = '0;
    case (avs_address_i)
      HOFS_ADDR: rd = {20'h0_0000, q.maddr};
      HOFS_WLO:  rd = q.wdat[31:0];
      HOFS_WHI:  rd = q.wdat[63:32];
      HOFS_CMD:  rd = {30'h0000_0000, q.we, 1'b0};
      HOFS_STAT: rd = {30'h0000_0000, q.done, ~idle};
      HOFS_RLO:  rd = q.rsp[31:0];
      HOFS_RHI:  rd = q.rsp[63:32];
      HOFS_PEND: rd = {30'h0000_0000, q.pend};
      HOFS_VEC:  rd = q.vec;
      default:   rd = 32'h0000_0000;
    endcase
    mv = be_merge(rd, avs_writedata_i, avs_byteenable_i);
    if (~q.aack) n.rdat = rd;
    // Command words are frozen while a transfer is held on the link
    if (wr_hit) begin
      case (avs_address_i)
        HOFS_ADDR: if (idle) n.maddr = mv[AW-1:0];
        HOFS_WLO:  if (idle) n.wdat[31:0] = mv;
        HOFS_WHI:  if (idle) n.wdat[63:32] = mv;
        HOFS_CMD: begin
          if (idle) n.we = mv[CMD_WR_BIT];
          // Claim and threshold set-up are issued by software through here
          if (idle & avs_byteenable_i[0] & avs_writedata_i[CMD_GO_BIT]) n.st = CET_REQ;
        end
        HOFS_STAT: clr_d = avs_byteenable_i[0] & avs_writedata_i[STAT_DONE_BIT];
        HOFS_PEND: clr_p = avs_byteenable_i[0] ? avs_writedata_i[NUM_LP-1:0] : '0;
        HOFS_VEC:  n.vec = mv;
        default: ;
      endcase
    end
    unique case (q.st)
      CET_IDLE: ;
      CET_REQ: begin
        if (bus.ack) begin
          n.st  = CET_IDLE;
          n.rsp = bus.rdata;
          set_d = 1'b1;
        end
      end
    endcase
    // Arrivals win over a clear in the same cycle
    n.done = (q.done & ~clr_d) | set_d;
    n.pend = (q.pend & ~clr_p) | (bus.irq & {NUM_LP{~q.vec[VEC_MASK_BIT]}});
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{st: CET_IDLE, vec: VEC_RESET, default: '0};
    end else begin
      q <= n;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign bus.req           = (q.st == CET_REQ);
  assign bus.we            = q.we;
  assign bus.addr          = q.maddr;
  assign bus.wdata         = q.wdat;
  assign avs_readdata_o    = q.rdat;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~q.aack;
  assign lp_irq_o          = q.pend;
  assign lp_vector_o       = q.vec[7:0];

endmodule

`default_nettype wire

/* File: tb/cet_link_checker.sv */
// Concurrent checks on the link between the bank complex and the controller side
`timescale 1ns/1ns
`default_nettype none

module cet_link_checker
  import cet_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic              req,
  input  wire logic              we,
  input  wire logic [AW-1:0]     addr,
  input  wire logic [63:0]       wdata,
  input  wire logic [63:0]       rdata,
  input  wire logic              ack,
  input  wire logic [NUM_LP-1:0] irq
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // ------------------------------------------------------------
  // Link handshake
  // ------------------------------------------------------------
  ack_answer_a: assert property ($rose(req) |=> ack)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack |-> req && $past(req))
    else $error("ack without a standing request");
  req_release_a: assert property (ack |=> !req)
    else $error("request kept after ack");
  req_hold_a: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
    else $error("request changed before ack");
  // Read data only moves with an answer, so a late sampler still sees it
  rdata_hold_a: assert property ($changed(rdata) |-> ack)
    else $error("read data changed without ack");

  // ------------------------------------------------------------
  // Register contents and interrupt routing
  // ------------------------------------------------------------
  cap_read_a: assert property (ack && !we && addr == ADDR_CAP |-> rdata[CAP_TES_BIT] == CAP_TES_P &&
    rdata[CAP_CORRECTED_ERROR_INTERRUPT_BIT] == CAP_CORRECTED_ERROR_INTERRUPT_P && rdata[7:0] == 8'h04)
    else $error("capability word wrong");
  unsup_bank_a: assert property (ack && !we && addr == 12'h10F |-> rdata == 64'h0000_0000_0000_0000)
    else $error("unsupported bank threshold control not zero");
  ctl2_fields_a: assert property (ack && !we && addr[11:4] == 8'h10 && addr[1:0] == OFS_CTL2 |->
    rdata[63:31] == 33'h0_0000_0000 && rdata[29:15] == 15'h0000)
    else $error("unused threshold control bits not zero");
  irq_share_a: assert property (irq[1] |-> irq[0])
    else $error("second processor interrupted alone");

  cover property (ack && we);
  cover property (ack && !we);
  cover property (irq == 2'h3);
  cover property (irq == 2'h1);
endmodule

`default_nettype wire

/* File: tb/corrected_error_threshold_signaling_test.sv */
// Self-checking bench for the bank complex and controller side joined by the link
`timescale 1ns/1ns
`default_nettype none

module corrected_error_threshold_signaling_test;
  import cet_pkg::*;

  logic              clk_i, resetn_i, av_read, av_write, err_valid, err_cache, yellow, av_wait;
  logic [AW-1:0]     av_addr;
  logic [31:0]       av_wd, av_rdata, err_addr;
  logic [1:0]        err_bank, lp_irq;
  logic [LINE_W-1:0] err_line;
  logic [7:0]        lp_vec;
  logic [63:0]       q;
  int                err_count, n_checks;

  cet_if link();
  cet_dev cet_dev_inst (.clk_i(clk_i), .resetn_i(resetn_i), .bus(link), .err_valid_i(err_valid),
    .err_bank_i(err_bank), .err_addr_i(err_addr), .err_cache_i(err_cache), .err_line_i(err_line),
    .cache_yellow_o(yellow));
  cet_hst cet_hst_inst (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(av_addr), .avs_read_i(av_read),
    .avs_write_i(av_write), .avs_writedata_i(av_wd), .avs_byteenable_i(4'hF), .avs_readdata_o(av_rdata),
    .avs_waitrequest_o(av_wait), .lp_irq_o(lp_irq), .lp_vector_o(lp_vec), .bus(link));
  cet_link_checker chk_inst (.clk_i(clk_i), .resetn_i(resetn_i), .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .irq(link.irq));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic timeout();
    err_count++;
    $display("[FAIL] wait limit used up");
    final_report();
  endtask

  // Waitrequest and read data are taken at the rising edge, so the values settled in the cycle before are seen
  task automatic av_cycle(input logic wr, input logic [AW-1:0] a, input logic [31:0] d, output logic [31:0] r);
    int n = 0;
    @(posedge clk_i);
    av_addr  <= a;
    av_wd    <= d;
    av_write <= wr;
    av_read  <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (av_wait !== 1'b0 && n < 50);
    r = av_rdata;
    av_write <= 1'b0;
    av_read  <= 1'b0;
    if (n >= 50) timeout();
  endtask

  task automatic wr32(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    av_cycle(1'b1, a, d, r);
  endtask

  task automatic link_op(input logic wr, input logic [AW-1:0] a, input logic [63:0] d, output logic [63:0] r);
    logic [31:0] s, lo, hi;
    int n = 0;
    wr32(HOFS_ADDR, {20'h0_0000, a});
    wr32(HOFS_WLO, d[31:0]);
    wr32(HOFS_WHI, d[63:32]);
    wr32(HOFS_CMD, {30'h0000_0000, wr, 1'b1});
    do begin
      av_cycle(1'b0, HOFS_STAT, 32'h0000_0000, s);
      n++;
    end while (s[STAT_DONE_BIT] !== 1'b1 && n < 20);
    if (n >= 20) timeout();
    wr32(HOFS_STAT, 32'h0000_0002);
    av_cycle(1'b0, HOFS_RLO, 32'h0000_0000, lo);
    av_cycle(1'b0, HOFS_RHI, 32'h0000_0000, hi);
    r = {hi, lo};
  endtask

  function automatic logic [AW-1:0] breg(input int i, input logic [1:0] o);
    return ADDR_BANK_BASE + AW'(4 * i) + AW'(o);
  endfunction

  task automatic err_evt(input logic [1:0] b, input logic c, input logic [3:0] l, input logic [31:0] a);
    @(posedge clk_i);
    err_valid <= 1'b1;
    err_bank  <= b;
    err_cache <= c;
    err_line  <= l;
    err_addr  <= a;
    @(posedge clk_i);
    err_valid <= 1'b0;
  endtask

  // Latency to pending is fixed at a few cycles, ten leaves margin
  task automatic ev_case(input int b, input logic [63:0] ctl2, input int nev, input logic [1:0] exp);
    link_op(1'b1, breg(b, OFS_CTL2), ctl2, q);
    link_op(1'b1, breg(b, OFS_STATUS), 64'h0, q);
    for (int k = 1; k <= nev; k++) begin
      err_evt(2'(b), 1'b0, 4'h0, 32'h0000_0100);
      repeat (10) @(posedge clk_i);
      chk("pending", {62'h0, lp_irq}, (k == nev) ? {62'h0, exp} : 64'h0);
    end
    wr32(HOFS_PEND, 32'h0000_0003);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    link_op(1'b0, ADDR_CAP, 64'h0, q);
    chk("tes bit", {63'h0, q[CAP_TES_BIT]}, {63'h0, CAP_TES_P});
    for (int i = 0; i < NUM_BANKS; i++) begin
      link_op(1'b0, breg(i, OFS_CTL2), 64'h0, q);
      chk("ctl2 reset", q, 64'h0);
    end
    av_cycle(1'b0, 12'h030, 32'h0000_0000, r);
    chk("unmapped", {32'h0, r}, 64'h0);
    $display("reset test done");
  endtask

  task automatic t_claim();
    for (int i = 0; i < NUM_BANKS; i++) begin
      link_op(1'b1, breg(i, OFS_CTL2), 64'hFFFF_FFFF_FFFF_FFFF, q);
      link_op(1'b0, breg(i, OFS_CTL2), 64'h0, q);
      chk("claim", q, BANK_THR_SUP[i] ? 64'h4000_7FFF : 64'h0);
    end
    $display("claim test done");
  endtask

  task automatic t_irq();
    wr32(HOFS_VEC, 32'h0000_005A);
    // The write lands on the edge the task returns at, so the entry is read one edge later
    @(posedge clk_i);
    chk("vector", {56'h0, lp_vec}, 64'h5A);
    // Bank error control stays zero throughout: interrupts must not depend on it
    ev_case(1, 64'h4000_0001, 1, 2'h3);
    ev_case(0, 64'h4000_0001, 1, 2'h1);
    ev_case(2, 64'h4000_0003, 3, 2'h3);
    ev_case(2, 64'h0000_0001, 1, 2'h0);
    ev_case(3, 64'h4000_0001, 1, 2'h0);
    $display("interrupt test done");
  endtask

  task automatic t_status();
    link_op(1'b1, breg(0, OFS_STATUS), 64'h0, q);
    err_evt(2'h0, 1'b0, 4'h0, 32'h1234_5670);
    err_evt(2'h0, 1'b0, 4'h0, 32'h1234_5670);
    link_op(1'b0, breg(0, OFS_STATUS), 64'h0, q);
    chk("status", q, 64'h8000_0080_0000_0000);
    link_op(1'b0, ADDR_LEG_TYPE, 64'h0, q);
    chk("legacy type", q, 64'h8000_0080_0000_0000);
    link_op(1'b0, ADDR_LEG_ADDR, 64'h0, q);
    chk("legacy addr", q, 64'h0000_0000_1234_5670);
    wr32(HOFS_PEND, 32'h0000_0003);
    $display("status test done");
  endtask

  task automatic t_health();
    logic [3:0] seq [9] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3};
    for (int k = 0; k < 9; k++) begin
      err_evt(2'h3, 1'b1, seq[k], 32'h0000_0000);
      repeat (4) @(posedge clk_i);
      chk("health", {63'h0, yellow}, {63'h0, k == 8});
    end
    $display("health test done");
  endtask

  // ------------------------------------------------------------
  // Clock, reset and sequence
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    {resetn_i, av_read, av_write, err_valid, err_cache} = '0;
    {av_addr, av_wd, err_addr, err_bank, err_line} = '0;
    err_count = 0;
    n_checks = 0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_claim();
    t_irq();
    t_status();
    t_health();
    final_report();
  end
endmodule

`default_nettype wire
